// ---- common/eprom_prog_pkg.sv ----
package eprom_prog_pkg;
  // ==========================================================
  // geometry
  localparam int ADDR_W = 13;
  localparam int BYTE_W = 8;
  localparam int TOP_BIT = 7;     // top byte line position
  localparam int A4_POS = 4;      // addr bit four position
  localparam int A6_POS = 6;      // addr bit six position
  // ==========================================================
  // timing at 20 MHz
  localparam int CLK_NS = 50;
  localparam int SETUP_NS = 1000;          // address/data setup before strobe
  localparam int STROBE_NS = 1000;         // read/verify strobe width
  localparam int PRIME_US = 1000;          // prime pulse, 1 ms
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRIME_CYC = (PRIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int FINAL_MULT = 4;           // final pulse = 4 x prime count
  localparam int MAX_PRIME = 15;
  localparam int CNT_W = 24;
  // ==========================================================
  // commands
  typedef enum logic [2:0] {
    CMD_READ, CMD_PROGRAM, CMD_PROTECT, CMD_PROT_VERIFY, CMD_IDLE
  } cmd_t;
endpackage

// ---- rtl/eprom_programmer.sv ----
// Overview of operation
// - read: select low then pulse strobe low
// - protect only after all programming done
// - protect: all high, bit four, pulse top
// - protect verify always follows protect
// - verify: select, strobe low, bit six low
// - prime pulses verified, fifteen at most
`timescale 1ns/1ps
module eprom_programmer
  import eprom_prog_pkg::*;
#(
  parameter int PRIME_CYCLES = PRIME_CYC
)(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire cmd_t              cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [BYTE_W-1:0] cmd_data,
  input  wire logic              all_programmed,
  output logic                   done,
  output logic [BYTE_W-1:0]      rd_data,
  output logic                   fail,
  output logic                   locked,
  output logic                   select_n,
  output logic                   out_strobe_n,
  output logic                   burn_pulse_n,
  output logic                   test_mode_pin,
  output logic [ADDR_W-1:0]      addr,
  output logic [BYTE_W-1:0]      byte_lines_o,
  output logic [BYTE_W-1:0]      byte_lines_oe,
  input  wire logic [BYTE_W-1:0] byte_lines_i
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_RSTROBE, ST_BURN, ST_PVER, ST_FINAL, ST_LOCK_PULSE,
    ST_LVER, ST_DONE
  } state_t;

  state_t            state_q;
  cmd_t              op_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [3:0]        prime_q;
  logic [BYTE_W-1:0] data_q;
  logic [BYTE_W-1:0] sync1_q;
  logic [BYTE_W-1:0] sync2_q;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction

  // ==========================================================
  // pin input synchroniser
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end
    else
    begin
      sync1_q <= byte_lines_i;
      sync2_q <= sync1_q;
    end

  assign cmd_ready = (state_q == ST_IDLE);
  wire   timeout   = (cnt_q == '0);
  // all bits compared for equality; a one over a burnt zero never matches
  wire   match     = ((sync2_q | data_q) == sync2_q) && ((sync2_q & data_q) == sync2_q);

  // ==========================================================
  // sequencer
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      op_q    <= CMD_IDLE;
      cnt_q   <= '0;
      prime_q <= 4'h0;
      data_q  <= 8'h00;
      addr    <= '0;
      rd_data <= 8'h00;
      fail    <= 1'b0;
      locked  <= 1'b0;
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!timeout)
        cnt_q <= cnt_q - 1'b1;
      unique case (state_q)
        ST_IDLE:
          // protect refused until programming is declared done
          if (cmd_valid && !(cmd_op == CMD_PROTECT && !all_programmed))
          begin
            op_q    <= cmd_op;
            addr    <= cmd_addr;
            data_q  <= cmd_data;
            prime_q <= 4'h0;
            fail    <= 1'b0;
            cnt_q   <= cyc(SETUP_CYC);
            state_q <= ST_SETUP;
          end
        ST_SETUP:
          if (timeout)
          begin
            unique case (op_q)
              CMD_PROGRAM:
              begin
                cnt_q   <= cyc(PRIME_CYCLES);
                prime_q <= prime_q + 4'h1;
                state_q <= ST_BURN;
              end
              CMD_PROTECT:
              begin
                // bit four high during the lock pulse
                addr[A4_POS] <= 1'b1;
                cnt_q        <= cyc(PRIME_CYCLES);
                state_q      <= ST_LOCK_PULSE;
              end
              CMD_PROT_VERIFY:
              begin
                addr[A6_POS] <= 1'b0;
                cnt_q        <= cyc(STROBE_CYC);
                state_q      <= ST_LVER;
              end
              default:
              begin
                cnt_q   <= cyc(STROBE_CYC);
                state_q <= ST_RSTROBE;
              end
            endcase
          end
        ST_RSTROBE:
          if (timeout)
          begin
            // capture byte at end of strobe
            rd_data <= sync2_q;
            done    <= 1'b1;
            state_q <= ST_IDLE;
          end
        ST_BURN:
          if (timeout)
          begin
            cnt_q   <= cyc(STROBE_CYC);
            state_q <= ST_PVER;
          end
        ST_PVER:
          if (timeout)
          begin
            // retry prime pulses up to fifteen
            if (match)
            begin
              cnt_q   <= CNT_W'(FINAL_MULT * PRIME_CYCLES * prime_q - 1);
              state_q <= ST_FINAL;
            end
            else if (prime_q == 4'(MAX_PRIME))
            begin
              fail    <= 1'b1;
              done    <= 1'b1;
              state_q <= ST_IDLE;
            end
            else
            begin
              prime_q <= prime_q + 4'h1;
              cnt_q   <= cyc(PRIME_CYCLES);
              state_q <= ST_BURN;
            end
          end
        ST_FINAL:
          if (timeout)
          begin
            done    <= 1'b1;
            state_q <= ST_IDLE;
          end
        ST_LOCK_PULSE:
          if (timeout)
          begin
            // protect chains into verify
            // through setup, so select is low before the strobe falls
            addr    <= '0;
            cnt_q   <= cyc(SETUP_CYC);
            op_q    <= CMD_PROT_VERIFY;
            state_q <= ST_SETUP;
          end
        ST_LVER:
          if (timeout)
          begin
            locked  <= ~sync2_q[TOP_BIT];
            done    <= 1'b1;
            state_q <= ST_IDLE;
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end

  // ==========================================================
  // pin levels per state
  always_comb
  begin
    // idle keeps select and burn high, inhibiting writes
    select_n      = 1'b1;
    out_strobe_n  = 1'b1;
    burn_pulse_n  = 1'b1;
    test_mode_pin = 1'b0;
    byte_lines_o  = 8'hff;
    byte_lines_oe = 8'h00;
    unique case (state_q)
      ST_SETUP:
      begin
        select_n      = (op_q == CMD_PROTECT);
        test_mode_pin = (op_q == CMD_PROTECT) || (op_q == CMD_PROT_VERIFY);
        byte_lines_oe = (op_q == CMD_PROGRAM) ? 8'hff : 8'h00;
        byte_lines_o  = data_q;
        // top line parked high
        // a floating top line could burn the lock before the real pulse
        if (op_q == CMD_PROTECT)
        begin
          byte_lines_oe[TOP_BIT] = 1'b1;
          byte_lines_o[TOP_BIT]  = 1'b1;
        end
      end
      ST_RSTROBE:
      begin
        select_n     = 1'b0;
        out_strobe_n = 1'b0;
      end
      ST_BURN, ST_FINAL:
      begin
        select_n      = 1'b0;
        burn_pulse_n  = 1'b0;
        byte_lines_oe = 8'hff;
        byte_lines_o  = data_q;
      end
      ST_PVER:
      begin
        select_n     = 1'b0;
        out_strobe_n = 1'b0;
      end
      ST_LOCK_PULSE:
      begin
        // only top line driven, pulsed low
        test_mode_pin          = 1'b1;
        byte_lines_oe[TOP_BIT] = 1'b1;
        byte_lines_o[TOP_BIT]  = 1'b0;
      end
      ST_LVER:
      begin
        select_n      = 1'b0;
        out_strobe_n  = 1'b0;
        test_mode_pin = 1'b1;
      end
      default:
      begin
        // strobe and burn high, lines floating
        byte_lines_oe = 8'h00;
      end
    endcase
  end
endmodule // eprom_programmer

// ---- sim/prog_chk.sv ----
`timescale 1ns/1ps
// ==========================================
// pin protocol checker
module prog_chk
  import eprom_prog_pkg::*;
#(
  parameter int PRIME_CYCLES = 5
)(
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire logic              cmd_valid,
  input wire logic              cmd_ready,
  input wire cmd_t              cmd_op,
  input wire logic              all_programmed,
  input wire logic              fail,
  input wire logic              select_n,
  input wire logic              out_strobe_n,
  input wire logic              burn_pulse_n,
  input wire logic              test_mode_pin,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [BYTE_W-1:0] byte_lines_o,
  input wire logic [BYTE_W-1:0] byte_lines_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic       burn_q;
  logic [4:0] prime_q;
  // burn pulses, prime and final, since the last taken command
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      burn_q  <= 1'b1;
      prime_q <= 5'h00;
    end
    else
    begin
      burn_q <= burn_pulse_n;
      if (cmd_valid && cmd_ready)
        prime_q <= 5'h00;
      else if (burn_q && !burn_pulse_n)
        prime_q <= prime_q + 5'h01;
    end
  end
  sequence prot_pulse;
    test_mode_pin && byte_lines_oe[TOP_BIT] && !byte_lines_o[TOP_BIT];
  endsequence
  sequence ver_strobe;
    test_mode_pin && !out_strobe_n && !select_n;
  endsequence
  // end of the lock pulse: top line released by the host
  sequence pulse_end;
    prot_pulse ##1 !byte_lines_oe[TOP_BIT];
  endsequence
  a_read_select_first: assert property ($fell(out_strobe_n) |-> !$past(select_n))
    else $error("strobe fell without select");
  a_protect_levels: assert property (prot_pulse |->
    select_n && out_strobe_n && burn_pulse_n && addr[A4_POS])
    else $error("protect pulse with wrong levels");
  a_verify_levels: assert property (ver_strobe |-> burn_pulse_n && !addr[A6_POS])
    else $error("protect verify with wrong levels");
  a_verify_follows: assert property (pulse_end |-> ##[1:100] ver_strobe)
    else $error("no verify after protect");
  a_protect_needs_permit: assert property (cmd_valid && cmd_ready &&
    cmd_op == CMD_PROTECT && !all_programmed |=> !test_mode_pin [*8])
    else $error("protect started without permit");
  a_fail_prime_count: assert property ($rose(fail) |-> prime_q == 5'(MAX_PRIME))
    else $error("gave up after wrong prime count");
  a_no_drive_clash: assert property (!out_strobe_n |-> byte_lines_oe == '0)
    else $error("host drove during device output");
endmodule // prog_chk

bind eprom_programmer prog_chk #(.PRIME_CYCLES(PRIME_CYCLES)) u_chk (.ref_clk(ref_clk),
  .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
  .all_programmed(all_programmed), .fail(fail), .select_n(select_n),
  .out_strobe_n(out_strobe_n), .burn_pulse_n(burn_pulse_n), .test_mode_pin(test_mode_pin),
  .addr(addr), .byte_lines_o(byte_lines_o), .byte_lines_oe(byte_lines_oe));

// ---- sim/eprom_model.sv ----
`timescale 1ns/1ps
// ==========================================
// behavioural device array with lock cell
module eprom_model
  import eprom_prog_pkg::*;
(
  input wire logic              select_n,
  input wire logic              out_strobe_n,
  input wire logic              burn_pulse_n,
  input wire logic              test_mode_pin,
  input wire logic              erase,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [BYTE_W-1:0] dq,
  output logic [BYTE_W-1:0]     dev_o,
  output logic [BYTE_W-1:0]     dev_oe
);
  logic [BYTE_W-1:0] mem [2**ADDR_W];
  logic              lock_cell;
  logic              rd;
  logic              pv;
  // only a whole erase sets cells back to one
  always @(posedge erase)
  begin
    foreach (mem[i]) mem[i] = 8'hff;
    lock_cell = 1'b1;
  end
  // burn clears bits only while selected
  always @(negedge burn_pulse_n)
    if (!select_n && out_strobe_n && !test_mode_pin)
      mem[addr] = mem[addr] & dq;
  // lock cell burnt by top line pulse
  always @(negedge dq[TOP_BIT])
    if (test_mode_pin && select_n && out_strobe_n && burn_pulse_n && addr[A4_POS])
      lock_cell = 1'b0;
  assign rd = !select_n && !out_strobe_n && burn_pulse_n;
  assign pv = rd && test_mode_pin && !addr[A6_POS];
  assign dev_oe = pv ? 8'h80 : (rd && !test_mode_pin && lock_cell) ? 8'hff : 8'h00;
  assign dev_o = pv ? {lock_cell, 7'h00} : mem[addr];
endmodule // eprom_model

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
// ==========================================
// bench top
module tb;
  import eprom_prog_pkg::*;
  logic ref_clk = 0, reset_n = 0, cmd_valid = 0, all_programmed = 0, erase = 0;
  logic cmd_ready, done, fail, locked, select_n, out_strobe_n, burn_pulse_n, test_mode_pin;
  cmd_t cmd_op = CMD_IDLE;
  logic [ADDR_W-1:0] cmd_addr = '0, addr;
  logic [BYTE_W-1:0] cmd_data = '0, rd_data, byte_lines_o, byte_lines_oe, dq, dev_o, dev_oe;
  logic [BYTE_W-1:0] flt_q = 8'h5a;  // undriven lines wander, never settle
  int error_cnt = 0, check_count = 0;
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) flt_q <= ~flt_q;
  // released lines show the wander, not the last driven value
  assign dq = (byte_lines_oe & byte_lines_o) | (dev_oe & dev_o)
            | (~byte_lines_oe & ~dev_oe & flt_q);
  eprom_programmer #(.PRIME_CYCLES(5)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .all_programmed(all_programmed), .done(done), .rd_data(rd_data),
    .fail(fail), .locked(locked), .select_n(select_n), .out_strobe_n(out_strobe_n),
    .burn_pulse_n(burn_pulse_n), .test_mode_pin(test_mode_pin), .addr(addr),
    .byte_lines_o(byte_lines_o), .byte_lines_oe(byte_lines_oe), .byte_lines_i(dq));
  eprom_model model (.select_n(select_n), .out_strobe_n(out_strobe_n),
    .burn_pulse_n(burn_pulse_n), .test_mode_pin(test_mode_pin), .erase(erase),
    .addr(addr), .dq(dq), .dev_o(dev_o), .dev_oe(dev_oe));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one command, bounded wait for its done pulse
  task automatic run_cmd(input cmd_t op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 3000 && done !== 1'b1; n++)
    begin
      @(posedge ref_clk);
      #1;
    end
    if (n >= 3000)
    begin
      `CHK("done", 1'b1, done)
      complete_run();
    end
  endtask
  task automatic t_program();
    run_cmd(CMD_READ, 13'h0123, 8'h00);
    `CHK("rd_data", 8'hff, rd_data)
    run_cmd(CMD_PROGRAM, 13'h0123, 8'h3c);
    `CHK("fail", 1'b0, fail)
    run_cmd(CMD_IDLE, 13'h0123, 8'h00);
    `CHK("rd_data", 8'h3c, rd_data)
    run_cmd(CMD_PROGRAM, 13'h0123, 8'hff);
    `CHK("fail", 1'b1, fail)
    $display("test program done");
  endtask
  // protect without permit is ignored, then done with permit
  task automatic t_protect();
    int seen;
    seen = 0;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= CMD_PROTECT;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    repeat (80) @(posedge ref_clk) seen += (done === 1'b1);
    `CHK("done", 0, seen)
    `CHK("cmd_ready", 1'b1, cmd_ready)
    all_programmed <= 1'b1;
    run_cmd(CMD_PROTECT, 13'h0010, 8'h00);
    `CHK("locked", 1'b1, locked)
    run_cmd(CMD_READ, 13'h0123, 8'h00);
    `CHK("open read", 1'b0, rd_data === 8'h3c)
    run_cmd(CMD_PROT_VERIFY, 13'h0000, 8'h00);
    `CHK("locked", 1'b1, locked)
    $display("test protect done");
  endtask
  task automatic t_erase();
    erase <= 1'b1;
    @(posedge ref_clk);
    erase <= 1'b0;
    run_cmd(CMD_PROT_VERIFY, 13'h0000, 8'h00);
    `CHK("locked", 1'b0, locked)
    run_cmd(CMD_READ, 13'h0123, 8'h00);
    `CHK("rd_data", 8'hff, rd_data)
    $display("test erase done");
  endtask
  initial
  begin
    #10 erase = 1'b1;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    erase <= 1'b0;
    t_program();
    t_protect();
    t_erase();
    complete_run();
  end
endmodule // tb
